// ---- rtl/fcb_branch.sv ----
`timescale 1ns/1ns
// Behaviour
// - Opcode E3h branches only when carry is zero, else falls through.
// - Opcode E7h branches only when negative is zero.
// - Opcode E5h branches only when overflow is zero.
// - A taken branch loads PC with PC+2 plus twice the signed 8-bit offset.
// - One cycle when not taken, two cycles when taken.
// - Q1 decode, Q2 read offset, Q3 process, Q4 write PC if taken; taken adds a nop cycle.
// - Opcode E6h branches only when negative is one, with the same target and timing.
module fcb_branch
  import fcb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Instruction word and status flags
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_status,
  // Program counter, sequencing and status flags
  output logic [fcb_pkg::PC_W-1:0] o_pc,
  output logic [1:0] o_phase,
  output logic o_flush,
  output logic o_branch_taken,
  output logic [7:0] o_status
);
  import fcb_pkg::*;

  // ----------------------------------------------------------------
  // State and next values
  // ----------------------------------------------------------------
  fcb_phase_e phase_r;
  fcb_phase_e phase_nxt;
  logic [15:0] instr_r;
  logic [15:0] instr_nxt;
  logic [7:0] offset_r;
  logic [7:0] offset_nxt;
  logic taken_r;
  logic taken_nxt;
  logic flush_r;
  logic flush_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] target_r;
  logic [PC_W-1:0] target_nxt;
  logic [7:0] status_r;

  // ----------------------------------------------------------------
  // Phase decode
  // ----------------------------------------------------------------
  wire in_q1 = (phase_r == PH_Q1);
  wire in_q2 = (phase_r == PH_Q2);
  wire in_q3 = (phase_r == PH_Q3);
  wire in_q4 = (phase_r == PH_Q4);
  // Flush cycles run the phases but refuse the fetched word
  wire fetch_en = in_q1 & ~flush_r;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  wire [7:0] op_hi = instr_r[15:8];
  wire dec_carry_clear = (op_hi == OP_BRANCH_IF_CARRY_CLEAR);
  wire dec_neg_clear = (op_hi == OP_BRANCH_IF_NEGATIVE_CLEAR);
  wire dec_ovf_clear = (op_hi == OP_BRANCH_IF_OVERFLOW_CLEAR);
  wire dec_neg_set = (op_hi == OP_BRANCH_IF_NEGATIVE);
  wire dec_any = dec_carry_clear | dec_neg_clear | dec_ovf_clear | dec_neg_set;
  wire flag_c = i_status[FLAG_C];
  wire flag_n = i_status[FLAG_N];
  wire flag_ov = i_status[FLAG_OV];
  wire cond_ok = (dec_carry_clear & ~flag_c) | (dec_neg_clear & ~flag_n)
    | (dec_ovf_clear & ~flag_ov) | (dec_neg_set & flag_n);

  // ----------------------------------------------------------------
  // Target arithmetic
  // ----------------------------------------------------------------
  // Offset is signed and counts words, so it is sign extended and doubled
  wire [PC_W-1:0] offset_x2 = {{(PC_W-9){offset_r[7]}}, offset_r, 1'b0};
  wire [PC_W-1:0] pc_inc = pc_r + PC_STEP;
  wire [PC_W-1:0] target_sum = pc_inc + offset_x2;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb
  begin
    phase_nxt = PH_Q1;
    unique case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
    endcase
  end

  assign instr_nxt = fetch_en ? i_instr : instr_r;
  assign offset_nxt = in_q2 ? instr_r[7:0] : offset_r;
  assign taken_nxt = in_q3 & ~flush_r & cond_ok;
  assign target_nxt = in_q3 ? target_sum : target_r;
  // A taken branch turns the following instruction cycle into a flush cycle
  assign flush_nxt = in_q4 ? taken_r : flush_r;
  // The flush cycle does not advance the counter; fetch is handled outside
  wire [PC_W-1:0] pc_q4 = taken_r ? target_r : (flush_r ? pc_r : pc_inc);
  assign pc_nxt = in_q4 ? pc_q4 : pc_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      phase_r <= PH_Q1;
      taken_r <= 1'b0;
      flush_r <= 1'b0;
      pc_r <= PC_RESET;
      target_r <= PC_RESET;
    end
    else
    begin
      phase_r <= phase_nxt;
      taken_r <= taken_nxt;
      flush_r <= flush_nxt;
      pc_r <= pc_nxt;
      target_r <= target_nxt;
    end
  end

  // Instruction latch and flag copy
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      instr_r <= INSTR_RESET;
      offset_r <= OFFSET_RESET;
      status_r <= STATUS_RESET;
    end
    else
    begin
      instr_r <= instr_nxt;
      offset_r <= offset_nxt;
      status_r <= i_status;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pc = pc_r;
  assign o_phase = phase_r;
  assign o_flush = flush_r;
  assign o_branch_taken = taken_r;
  // Flags are only carried through a register; no branch writes them
  assign o_status = status_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Branch decisions, one per opcode
  a_carry_clear_taken: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q3 && !flush_r && dec_carry_clear) |=> (taken_r == !$past(flag_c)))
    else $error("carry clear branch decision wrong");
  a_neg_clear_taken: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q3 && !flush_r && dec_neg_clear) |=> (taken_r == !$past(flag_n)))
    else $error("negative clear branch decision wrong");
  a_ovf_clear_taken: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q3 && !flush_r && dec_ovf_clear) |=> (taken_r == !$past(flag_ov)))
    else $error("overflow clear branch decision wrong");
  a_neg_set_taken: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q3 && !flush_r && dec_neg_set) |=> (taken_r == $past(flag_n)))
    else $error("negative branch decision wrong");

  // Target and cycle count
  a_target_value: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q4 && taken_r) |=>
      (pc_r == $past(pc_r) + PC_STEP + {{(PC_W-9){$past(offset_r[7])}}, $past(offset_r), 1'b0}))
    else $error("branch target wrong");
  sequence s_taken_q4;
    phase_r == PH_Q4 && taken_r;
  endsequence
  sequence s_flush_cycle;
    flush_r [*4] ##1 !flush_r;
  endsequence
  a_taken_two_cycles: assert property (@(posedge i_clk) disable iff (i_reset)
    s_taken_q4 |=> s_flush_cycle)
    else $error("taken branch not two cycles");
  a_flush_from_taken: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(flush_r) |-> $past(taken_r))
    else $error("flush cycle without taken branch");
  a_flush_no_write: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q4 && flush_r) |=> (pc_r == $past(pc_r) && !taken_r))
    else $error("flush cycle changed program counter");
  a_fall_through: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q4 && !taken_r && !flush_r) |=> (pc_r == $past(pc_r) + PC_STEP && !flush_r))
    else $error("not taken branch did not fall through");
  a_other_op_falls: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q3 && !dec_any) |=> !taken_r)
    else $error("non branch opcode taken");

  // Phase discipline
  sequence s_four_phases;
    phase_r == PH_Q1 ##1 phase_r == PH_Q2 ##1 phase_r == PH_Q3 ##1 phase_r == PH_Q4;
  endsequence
  a_phase_order: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q1) |-> s_four_phases)
    else $error("phase order broken");
  a_taken_in_q4: assert property (@(posedge i_clk) disable iff (i_reset)
    taken_r |-> (phase_r == PH_Q4 && !flush_r))
    else $error("taken flag outside fourth phase");
  a_taken_clears: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q4) |=> !taken_r)
    else $error("taken flag held past fourth phase");
  a_offset_read: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q2) |=> (offset_r == $past(instr_r[7:0])))
    else $error("offset literal not read in second phase");
  a_flush_refuses: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r == PH_Q1 && flush_r) |=> (instr_r == $past(instr_r)))
    else $error("instruction fetched during flush cycle");
  a_pc_q4_only: assert property (@(posedge i_clk) disable iff (i_reset)
    (phase_r != PH_Q4) |=> (pc_r == $past(pc_r)))
    else $error("program counter written outside fourth phase");

  // Flags
  a_flags_kept: assert property (@(posedge i_clk) disable iff (i_reset)
    !$past(i_reset) |-> (o_status == $past(i_status)))
    else $error("status flags changed");
endmodule : fcb_branch

// ---- rtl/fcb_pkg.sv ----
package fcb_pkg;
  // Opcode high bytes
  localparam logic [7:0] OP_BRANCH_IF_CARRY_CLEAR = 8'hE3;
  localparam logic [7:0] OP_BRANCH_IF_NEGATIVE_CLEAR = 8'hE7;
  localparam logic [7:0] OP_BRANCH_IF_OVERFLOW_CLEAR = 8'hE5;
  localparam logic [7:0] OP_BRANCH_IF_NEGATIVE = 8'hE6;
  // Address widths and increments
  localparam int PC_W = 21;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] PC_RESET = 21'h000000;
  // Reset values of the instruction latch and the flag copy
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Status flag positions in the flag vector
  localparam int FLAG_C = 0;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  // Phases of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} fcb_phase_e;
endpackage : fcb_pkg

// ---- verif/fcb_branch_tb.sv ----
`timescale 1ns/1ns
module fcb_branch_tb;
  import fcb_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_status = 8'h00;
  logic [PC_W-1:0] o_pc;
  logic [1:0] o_phase;
  logic o_flush;
  logic o_branch_taken;
  logic [7:0] o_status;
  logic [PC_W-1:0] exp_pc = PC_RESET;
  int fail_count = 0;
  int n_checks = 0;
  always #5 i_clk = ~i_clk;
  fcb_branch dut (.i_clk(i_clk), .i_reset(i_reset), .i_instr(i_instr), .i_status(i_status),
    .o_pc(o_pc), .o_phase(o_phase), .o_flush(o_flush), .o_branch_taken(o_branch_taken),
    .o_status(o_status));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run;
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  // Starts one instruction at the first free Q1 and follows it to its end
  task automatic run_instr(input logic [7:0] op, input logic [7:0] n, input logic [7:0] st,
                           input logic tk);
    int k;
    for (k = 0; k < 12 && (o_phase !== 2'h0 || o_flush !== 1'b0); k++) step(1);
    if (k == 12)
    begin
      fail_count++;
      complete_run();
    end
    exp_pc = exp_pc + PC_STEP + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h000000);
    i_instr = {op, n};
    i_status = st;
    step(3);
    chk("phase", 21'h3, o_phase);
    chk("taken", tk, o_branch_taken);
    chk("status", st, o_status);
    step(1);
    chk("pc", exp_pc, o_pc);
    chk("flush", tk, o_flush);
    if (tk)
    begin
      i_instr = {OP_BRANCH_IF_CARRY_CLEAR, 8'h40};
      i_status = 8'h00;
      step(3);
      chk("nop taken", 1'b0, o_branch_taken);
      step(1);
      chk("nop pc", exp_pc, o_pc);
      chk("nop flush", 1'b0, o_flush);
    end
  endtask : run_instr
  task automatic sc_codes;
    logic [7:0] ops [4] = '{OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_NEGATIVE_CLEAR,
                            OP_BRANCH_IF_OVERFLOW_CLEAR, OP_BRANCH_IF_NEGATIVE};
    int bits [4] = '{FLAG_C, FLAG_N, FLAG_OV, FLAG_N};
    logic pols [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic f;
    logic [7:0] st;
    logic [7:0] n;
    for (int i = 0; i < 4; i++)
      for (int t = 0; t < 2; t++)
      begin
        f = (t == 1) ? pols[i] : ~pols[i];
        st = f ? (8'h01 << bits[i]) : ~(8'h01 << bits[i]);
        n = (i[0] ^ t[0]) ? 8'h80 : 8'h7F;
        run_instr(ops[i], n, st, t[0]);
      end
  endtask : sc_codes
  task automatic sc_reset_mid;
    run_instr(8'h0F, 8'h80, 8'h00, 1'b0);
    step(1);
    i_reset = 1'b1;
    step(1);
    chk("reset pc", PC_RESET, o_pc);
    chk("reset phase", 21'h0, o_phase);
    exp_pc = PC_RESET;
    i_reset = 1'b0;
    run_instr(OP_BRANCH_IF_NEGATIVE, 8'hFE, 8'h10, 1'b1);
  endtask : sc_reset_mid
  initial
  begin
    step(5);
    i_reset = 1'b0;
    sc_codes();
    sc_reset_mid();
    complete_run();
  end
endmodule : fcb_branch_tb
